/* File: hdl/rst_wake_pkg.sv */
package rst_wake_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned DEBOUNCE_MS     = 32;
    localparam int unsigned RESET_DELAY_MS  = 500;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned POWER_UP_CYC    = 16;
    localparam int unsigned RESET_HOLD_CYC  = 16;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_OFFSET    = 12'h008;
    localparam logic [11:0] MASK_OFFSET   = 12'h00c;
    localparam logic [11:0] TIMER_OFFSET  = 12'h010;
    localparam logic [11:0] WAKE_OFFSET   = 12'h014;

    // ctrl fields
    localparam int unsigned CTRL_ROLE_LSB   = 0;
    localparam int unsigned CTRL_SIMSW_BIT  = 4;
    localparam int unsigned CTRL_SLEEP_BIT  = 8;
    localparam int unsigned CTRL_PSM_BIT    = 9;
    localparam int unsigned CTRL_TIMEN_BIT  = 10;
    localparam int unsigned CTRL_REBOOT_BIT = 11;
    localparam int unsigned CTRL_GPOUT_BIT  = 12;
    localparam int unsigned CTRL_GPOE_BIT   = 13;

    // role codes
    localparam logic [3:0] ROLE_GPIO      = 4'h4;
    localparam logic [3:0] ROLE_RESET_OUT = 4'h0;

    // irq bits
    localparam int unsigned IRQ_EXT_RESET  = 0;
    localparam int unsigned IRQ_SLEEP_WAKE = 1;
    localparam int unsigned IRQ_PSM_WAKE   = 2;
    localparam int unsigned IRQ_W          = 3;

    // reset values
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    // only the terminal-ready line and card detect wake out of reset; io pins need setup
    localparam logic [4:0]  WAKE_RESET  = 5'h03;
    localparam logic [31:0] TIMER_RESET = 32'h0000_0000;

    typedef enum logic [4:0] {
        ST_POWER_UP = 5'b00001,
        ST_ACTIVE   = 5'b00010,
        ST_SLEEP    = 5'b00100,
        ST_PSM      = 5'b01000,
        ST_RESET    = 5'b10000
    } pstate_type;

    typedef struct packed {
        logic io_a;
        logic io_b;
        logic io_c;
        logic terminal_ready_line;
        logic card_presence_detect;
    } wake_pins_type;

    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_type;

endpackage : rst_wake_pkg

/* File: hdl/rst_wake_ctrl.sv */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - reset accepted after 32 ms continuous low
// - internal reset 500 ms after debounce satisfied
// - accepted reset clears cpu registers and ram
// - then restart as if power-on held low
// - reset-out pin low during reset, power-up
// - reset-out pin high after power-on completes
// - reset-out pin floats in deep power-save
// - role code 4 gpio, 0 reset-out, after reboot
// - sim switch enable gives pin to switch
// - light sleep wakes from five listed pins
// - either edge on monitored pin wakes
// - gpio wakes only when configured as wake
// - card detect edges both count as wake
// - deep power-save exit by timer or power-on
// - wake sources act only in own state
// - gpio pins reset with no pull enabled
module rst_wake_ctrl #(
    parameter int unsigned DEBOUNCE_CYCLES = rst_wake_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned RESET_DELAY_CYC = rst_wake_pkg::RESET_DELAY_CYC
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // external requests
    input  wire logic                        reset_request_n,
    input  wire logic                        power_on_request_n,
    // wake pins
    input  wire rst_wake_pkg::wake_pins_type wake_pins,
    // multi-function pin
    input  wire logic                        multi_function_pin_i,
    output logic                             multi_function_pin_o,
    output logic                             multi_function_pin_oe,
    output logic                             sim_select,
    // gpio pull controls
    output logic                             pull_up_en,
    output logic                             pull_down_en,
    // internal reset, ram clear and interrupt
    output logic                             cpu_reset,
    output logic                             ram_clear,
    output logic                             irq
);

    // ------------------------------------------------------------
    // request input sync and debounce
    // ------------------------------------------------------------
    localparam int unsigned IRQ_W_L = rst_wake_pkg::IRQ_W;

    logic                 req_s1_q;
    logic                 req_s2_q;
    logic [31:0]          deb_cnt_q;
    logic [31:0]          dly_cnt_q;
    logic                 deb_done_q;
    logic                 dly_run_q;
    rst_wake_pkg::pstate_type state_q;
    rst_wake_pkg::pstate_type state_d;
    logic [31:0]          cnt_q;
    logic [31:0]          ctrl_q;
    logic [4:0]           wake_en_q;
    logic [31:0]          timer_q;
    logic [31:0]          psm_cnt_q;
    logic [IRQ_W_L-1:0]   irq_stat_q;
    logic [IRQ_W_L-1:0]   irq_mask_q;
    logic [3:0]           role_q;
    logic                 simsw_q;
    logic [4:0]           wake_prev_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_s1_q <= 1'b1;
            req_s2_q <= 1'b1;
        end else begin
            req_s1_q <= reset_request_n;
            req_s2_q <= req_s1_q;
        end
    end

    // count restarts whenever the line goes high again
    wire deb_hit = (deb_cnt_q == DEBOUNCE_CYCLES - 1);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            deb_cnt_q  <= '0;
            deb_done_q <= 1'b0;
        end else if (req_s2_q) begin
            deb_cnt_q  <= '0;
            deb_done_q <= 1'b0;
        end else if (!deb_done_q) begin
            deb_cnt_q  <= deb_cnt_q + 32'h0000_0001;
            deb_done_q <= deb_hit;
        end
    end
    wire accept = deb_done_q == 1'b0 && !req_s2_q && deb_hit;

    // delay from accept to internal reset; runs on after pin release
    wire dly_hit = (dly_cnt_q == RESET_DELAY_CYC - 1);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dly_cnt_q <= '0;
            dly_run_q <= 1'b0;
        end else if (accept) begin
            dly_cnt_q <= '0;
            dly_run_q <= 1'b1;
        end else if (dly_run_q) begin
            dly_cnt_q <= dly_cnt_q + 32'h0000_0001;
            dly_run_q <= !dly_hit;
        end
    end
    wire int_reset = dly_run_q && dly_hit;

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    wire [4:0] wake_now  = wake_pins;
    wire [4:0] wake_edge = (wake_now ^ wake_prev_q) & wake_en_q;
    wire       sleep_wake = state_q == rst_wake_pkg::ST_SLEEP && |wake_edge;
    wire       timer_wake = ctrl_q[rst_wake_pkg::CTRL_TIMEN_BIT]
                            && psm_cnt_q == timer_q;
    wire       psm_wake   = state_q == rst_wake_pkg::ST_PSM
                            && (!power_on_request_n || timer_wake);
    wire       cnt_done   = cnt_q == 32'(rst_wake_pkg::POWER_UP_CYC - 1);
    wire       hold_done  = cnt_q == 32'(rst_wake_pkg::RESET_HOLD_CYC - 1);
    wire       reboot_cmd;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rst_wake_pkg::ST_RESET: begin
                if (hold_done) state_d = rst_wake_pkg::ST_POWER_UP;
            end
            rst_wake_pkg::ST_POWER_UP: begin
                if (cnt_done) state_d = rst_wake_pkg::ST_ACTIVE;
            end
            rst_wake_pkg::ST_ACTIVE: begin
                if (ctrl_q[rst_wake_pkg::CTRL_PSM_BIT])
                    state_d = rst_wake_pkg::ST_PSM;
                else if (ctrl_q[rst_wake_pkg::CTRL_SLEEP_BIT])
                    state_d = rst_wake_pkg::ST_SLEEP;
            end
            rst_wake_pkg::ST_SLEEP: begin
                if (sleep_wake) state_d = rst_wake_pkg::ST_ACTIVE;
            end
            rst_wake_pkg::ST_PSM: begin
                if (psm_wake) state_d = rst_wake_pkg::ST_POWER_UP;
            end
        endcase
        if (int_reset || reboot_cmd) state_d = rst_wake_pkg::ST_RESET;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q     <= rst_wake_pkg::ST_RESET;
            cnt_q       <= '0;
            wake_prev_q <= '0;
            psm_cnt_q   <= '0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= (state_d != state_q) ? '0 : cnt_q + 32'h0000_0001;
            wake_prev_q <= wake_now;
            psm_cnt_q   <= (state_q == rst_wake_pkg::ST_PSM && !timer_wake)
                           ? psm_cnt_q + 32'h0000_0001 : '0;
        end
    end

    // latch pin role only across the reset state, so changes need a reboot
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            role_q  <= rst_wake_pkg::ROLE_RESET_OUT;
            simsw_q <= 1'b0;
        end else if (state_q == rst_wake_pkg::ST_RESET) begin
            role_q  <= ctrl_q[rst_wake_pkg::CTRL_ROLE_LSB +: 4];
            simsw_q <= ctrl_q[rst_wake_pkg::CTRL_SIMSW_BIT];
        end
    end

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    wire acc     = psel && penable;
    wire wr      = acc && pwrite;
    wire sel_ctl = paddr == rst_wake_pkg::CTRL_OFFSET;
    wire sel_st  = paddr == rst_wake_pkg::STATUS_OFFSET;
    wire sel_irq = paddr == rst_wake_pkg::IRQ_OFFSET;
    wire sel_msk = paddr == rst_wake_pkg::MASK_OFFSET;
    wire sel_tmr = paddr == rst_wake_pkg::TIMER_OFFSET;
    wire sel_wk  = paddr == rst_wake_pkg::WAKE_OFFSET;
    wire mapped  = sel_ctl | sel_st | sel_irq | sel_msk | sel_tmr | sel_wk;
    assign reboot_cmd = wr && sel_ctl && pwdata[rst_wake_pkg::CTRL_REBOOT_BIT];

    wire [IRQ_W_L-1:0] irq_evt = {psm_wake, sleep_wake, int_reset};
    wire [IRQ_W_L-1:0] irq_clr = (wr && sel_irq) ? pwdata[IRQ_W_L-1:0] : '0;
    // sleep/psm requests self-clear on leaving active so a wake sticks
    wire leave_active = state_q == rst_wake_pkg::ST_ACTIVE
                        && state_d != rst_wake_pkg::ST_ACTIVE;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q     <= rst_wake_pkg::CTRL_RESET;
            wake_en_q  <= rst_wake_pkg::WAKE_RESET;
            timer_q    <= rst_wake_pkg::TIMER_RESET;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            if (wr && sel_ctl)
                ctrl_q <= pwdata & ~(32'h1 << rst_wake_pkg::CTRL_REBOOT_BIT);
            else if (leave_active)
                ctrl_q[rst_wake_pkg::CTRL_PSM_BIT:rst_wake_pkg::CTRL_SLEEP_BIT] <= 2'b00;
            if (int_reset)
                wake_en_q <= rst_wake_pkg::WAKE_RESET;
            else if (wr && sel_wk)
                wake_en_q <= pwdata[4:0];
            if (wr && sel_tmr)
                timer_q <= pwdata;
            if (wr && sel_msk)
                irq_mask_q <= pwdata[IRQ_W_L-1:0];
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;   // set wins
        end
    end

    wire [31:0] rd_mux =
        sel_ctl ? ctrl_q :
        sel_st  ? {27'h0, state_q} :
        sel_irq ? {29'h0, irq_stat_q} :
        sel_msk ? {29'h0, irq_mask_q} :
        sel_tmr ? timer_q :
        sel_wk  ? {27'h0, wake_en_q} : 32'h0;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) prdata <= '0;
        else if (psel && !penable && !pwrite) prdata <= rd_mux;
    end
    wire unmapped = !mapped;
    assign pready  = 1'b1;
    assign pslverr = acc && unmapped;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire in_reset  = state_q == rst_wake_pkg::ST_RESET;
    wire in_pup    = state_q == rst_wake_pkg::ST_POWER_UP;
    wire in_psm    = state_q == rst_wake_pkg::ST_PSM;
    wire is_rstout = !simsw_q && role_q == rst_wake_pkg::ROLE_RESET_OUT;
    wire is_gpio   = !simsw_q && role_q == rst_wake_pkg::ROLE_GPIO;
    rst_wake_pkg::pin_drive_type mfp_d;

    always_comb begin
        mfp_d = '{o: 1'b0, oe: 1'b0};
        if (simsw_q)
            mfp_d = '{o: ctrl_q[rst_wake_pkg::CTRL_GPOUT_BIT], oe: 1'b1};
        else if (is_rstout && in_psm)
            mfp_d = '{o: 1'b0, oe: 1'b0};
        else if (is_rstout)
            mfp_d = '{o: !(in_reset || in_pup), oe: 1'b1};
        else if (is_gpio)
            mfp_d = '{o: ctrl_q[rst_wake_pkg::CTRL_GPOUT_BIT],
                      oe: ctrl_q[rst_wake_pkg::CTRL_GPOE_BIT]};
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            multi_function_pin_o  <= 1'b0;
            multi_function_pin_oe <= 1'b1;
            sim_select            <= 1'b0;
            cpu_reset             <= 1'b1;
            ram_clear             <= 1'b0;
        end else begin
            multi_function_pin_o  <= mfp_d.o;
            multi_function_pin_oe <= mfp_d.oe;
            sim_select            <= simsw_q && multi_function_pin_i == multi_function_pin_i
                                     && ctrl_q[rst_wake_pkg::CTRL_GPOUT_BIT];
            cpu_reset             <= state_d == rst_wake_pkg::ST_RESET;
            ram_clear             <= int_reset;
        end
    end

    assign pull_up_en   = 1'b0;
    assign pull_down_en = 1'b0;
    assign irq          = |(irq_stat_q & irq_mask_q);

endmodule : rst_wake_ctrl

/* File: sim/rst_wake_ctrl_checker.sv */
`timescale 1ns/1ps
module rst_wake_ctrl_checker #(
    parameter int unsigned DEBOUNCE_CYCLES = 20,
    parameter int unsigned RESET_DELAY_CYC = 30
) (
    // clock, reset and bus
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // pins
    input wire logic        reset_request_n,
    input wire logic        multi_function_pin_o,
    input wire logic        multi_function_pin_oe,
    input wire logic        pull_up_en,
    input wire logic        pull_down_en,
    input wire logic        cpu_reset,
    input wire logic        ram_clear
);
    // ----------
    // helpers
    // ----------
    logic [31:0] low_q;
    logic [31:0] dly_q;
    logic [31:0] ctrl_q;
    logic [4:0]  up_q;
    logic        role0_q;
    wire         acc = !reset_request_n && low_q == DEBOUNCE_CYCLES;
    wire         ctrl_wr = psel && penable && pwrite && paddr == 12'h000;

    // role is only trusted from the second reset cycle on
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_q   <= 32'h0;
            dly_q   <= 32'h0;
            ctrl_q  <= 32'h0;
            up_q    <= 5'h00;
            role0_q <= 1'b1;
        end else begin
            low_q <= reset_request_n ? 32'h0 : low_q + 32'h1;
            if (acc)
                dly_q <= 32'h1;
            else if (dly_q != 32'h0 && dly_q < RESET_DELAY_CYC + 12)
                dly_q <= dly_q + 32'h1;
            else
                dly_q <= 32'h0;
            if (ctrl_wr)
                ctrl_q <= pwdata;
            if (cpu_reset)
                role0_q <= ctrl_q[4:0] == 5'h00;
            up_q <= cpu_reset ? 5'h00 : up_q + {4'h0, up_q != 5'h1f};
        end
    end

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_PULL: assert property (!pull_up_en && !pull_down_en)
        else $error("pull enabled");
    AST_EARLY: assert property (dly_q != 32'h0 && dly_q < RESET_DELAY_CYC - 1 |-> !cpu_reset)
        else $error("internal reset too early");
    AST_LATE: assert property (dly_q == RESET_DELAY_CYC + 8 |-> cpu_reset)
        else $error("internal reset missing");
    AST_HOLD: assert property ($rose(cpu_reset) |=> cpu_reset [*8])
        else $error("reset state too short");
    AST_RAM_PULSE: assert property (ram_clear |=> !ram_clear)
        else $error("ram clear not a pulse");
    AST_RAM_RST: assert property (ram_clear |-> ##[0:1] cpu_reset)
        else $error("ram clear without reset");
    AST_PIN_LOW: assert property (role0_q && (cpu_reset && $past(cpu_reset)
        || up_q inside {[5'h02:5'h0e]}) |-> multi_function_pin_oe && !multi_function_pin_o)
        else $error("reset out not low");
    AST_PIN_HIGH: assert property (role0_q && up_q == 5'h14
        |-> multi_function_pin_oe && multi_function_pin_o)
        else $error("reset out not high");
endmodule : rst_wake_ctrl_checker

bind rst_wake_ctrl rst_wake_ctrl_checker #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .RESET_DELAY_CYC(RESET_DELAY_CYC)
) rst_wake_ctrl_checker_inst (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .reset_request_n,
    .multi_function_pin_o, .multi_function_pin_oe, .pull_up_en, .pull_down_en,
    .cpu_reset, .ram_clear
);

/* File: sim/host_model.sv */
`timescale 1ns/1ps
module host_model (
    // clock and pin
    input  wire logic                   sys_clk,
    input  wire logic                   multi_function_pin_o,
    input  wire logic                   multi_function_pin_oe,
    output wire logic                   multi_function_pin_i,
    // requests
    output logic                        reset_request_n,
    output logic                        power_on_request_n,
    output rst_wake_pkg::wake_pins_type wake_pins
);
    // board pull-up, a released pin reads high
    assign multi_function_pin_i = multi_function_pin_oe ? multi_function_pin_o : 1'b1;

    initial begin
        reset_request_n    = 1'b1;
        power_on_request_n = 1'b1;
        wake_pins          = 5'h01; // card present
    end

    task hold_reset(input int unsigned n);
        @(posedge sys_clk);
        reset_request_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        reset_request_n <= 1'b1;
    endtask : hold_reset

    task flip_wake(input int unsigned k);
        @(posedge sys_clk);
        wake_pins[k] <= ~wake_pins[k];
    endtask : flip_wake

    task power_on();
        @(posedge sys_clk);
        power_on_request_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        power_on_request_n <= 1'b1;
    endtask : power_on
endmodule : host_model

/* File: sim/rst_wake_ctrl_tb.sv */
`timescale 1ns/1ps
module rst_wake_ctrl_tb;
    localparam int unsigned DEB = 20;
    localparam int unsigned DLY = 30;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, reset_request_n, power_on_request_n, irq;
    logic        multi_function_pin_i, multi_function_pin_o, multi_function_pin_oe;
    logic        sim_select, pull_up_en, pull_down_en, cpu_reset, ram_clear;
    rst_wake_pkg::wake_pins_type wake_pins;
    int          error_cnt  = 0;
    int          num_checks = 0;
    int          i;

    always #5 sys_clk = ~sys_clk;

    rst_wake_ctrl #(.DEBOUNCE_CYCLES(DEB), .RESET_DELAY_CYC(DLY)) rst_wake_ctrl_inst (
        .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .reset_request_n, .power_on_request_n, .wake_pins, .multi_function_pin_i,
        .multi_function_pin_o, .multi_function_pin_oe, .sim_select, .pull_up_en,
        .pull_down_en, .cpu_reset, .ram_clear, .irq
    );
    host_model host_model_inst (
        .sys_clk, .multi_function_pin_o, .multi_function_pin_oe, .multi_function_pin_i,
        .reset_request_n, .power_on_request_n, .wake_pins
    );

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    // master holds the request until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            check("pready", 32'h0, 32'h1);
            stop_test();
        end
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rd, e);
    endtask : rdc

    task wait_st(input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0);
            n++;
        end while (rd !== v && n < 100);
        check("state", rd, v);
        if (rd !== v)
            stop_test();
    endtask : wait_st

    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wait_st(32'h2);
        rdc(12'h000, 32'h0);
        rdc(12'h014, 32'h3);
        rdc(12'h010, 32'h0);
        rdc(12'h020, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        host_model_inst.hold_reset(DEB - 5);
        host_model_inst.hold_reset(DEB - 5);
        repeat (DEB + DLY + 20) @(posedge sys_clk);
        rdc(12'h004, 32'h2);
        apb(1'b1, 12'h00c, 32'h7);
        host_model_inst.hold_reset(DEB + 8);
        wait_st(32'h10);
        check("irq", {31'h0, irq}, 32'h1);
        wait_st(32'h2);
        apb(1'b1, 12'h00c, 32'h0);
        repeat (2) @(posedge sys_clk);
        check("irq", {31'h0, irq}, 32'h0);
        rdc(12'h008, 32'h1);
        apb(1'b1, 12'h008, 32'h1);
        rdc(12'h008, 32'h0);
        apb(1'b1, 12'h014, 32'h1f);
        for (i = 0; i < 5; i++) begin
            apb(1'b1, 12'h000, 32'h100);
            wait_st(32'h4);
            host_model_inst.power_on();
            rdc(12'h004, 32'h4);
            host_model_inst.flip_wake(i);
            wait_st(32'h2);
            rdc(12'h008, 32'h2);
            apb(1'b1, 12'h008, 32'h2);
        end
        apb(1'b1, 12'h014, 32'h3);
        apb(1'b1, 12'h000, 32'h100);
        wait_st(32'h4);
        host_model_inst.flip_wake(4);
        rdc(12'h004, 32'h4);
        host_model_inst.flip_wake(0);
        wait_st(32'h2);
        apb(1'b1, 12'h008, 32'h7);
        apb(1'b1, 12'h000, 32'h200);
        wait_st(32'h8);
        check("oe", {31'h0, multi_function_pin_oe}, 32'h0);
        host_model_inst.flip_wake(0);
        rdc(12'h004, 32'h8);
        host_model_inst.power_on();
        wait_st(32'h2);
        rdc(12'h008, 32'h4);
        apb(1'b1, 12'h010, 32'h40);
        apb(1'b1, 12'h000, 32'h600);
        wait_st(32'h8);
        wait_st(32'h2);
        repeat (2) @(posedge sys_clk);
        check("pin", {30'h0, multi_function_pin_oe, multi_function_pin_o}, 32'h3);
        apb(1'b1, 12'h000, 32'h2004);
        repeat (2) @(posedge sys_clk);
        check("pin", {31'h0, multi_function_pin_o}, 32'h1);
        apb(1'b1, 12'h000, 32'h2804);
        wait_st(32'h10);
        wait_st(32'h2);
        apb(1'b1, 12'h000, 32'h2004);
        repeat (2) @(posedge sys_clk);
        check("pin", {30'h0, multi_function_pin_oe, multi_function_pin_o}, 32'h2);
        apb(1'b1, 12'h000, 32'h1814);
        wait_st(32'h10);
        wait_st(32'h2);
        repeat (2) @(posedge sys_clk);
        check("sim", {31'h0, sim_select}, 32'h1);
        stop_test();
    end
endmodule : rst_wake_ctrl_tb
